/* File: verilog/afe_mode_config.sv */
// Register bank and mode decode of the sensor front end
`timescale 1ns/1ns
module afe_mode_config (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  // Bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_module_select_n,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  // Amplifier controls
  output logic [2:0]      o_feedback_gain_sel,
  output logic            o_ext_feedback,
  output logic [1:0]      o_load_sel,
  // Reference controls
  output logic            o_ref_external,
  output logic [1:0]      o_zero_sel,
  output logic            o_zero_bypass,
  output logic            o_bias_positive,
  output logic [4:0]      o_bias_pct,
  // Mode controls
  output logic            o_electrode_short_switch,
  output logic            o_control_amplifier_on,
  output logic            o_current_to_voltage_amp_on,
  output logic            o_amp_noninverting,
  output logic            o_temp_sensor_on,
  output logic            o_analog_output_pin_temp,
  output logic            o_feedback_pin_two_result,
  // Register view
  output logic [2:0]      o_operating_mode_sel,
  output logic            o_ready
);
  import afe_pkg::*;

  logic [7:0] status_r, status_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [7:0] amp_r, amp_nxt;
  logic [7:0] ref_r, ref_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] rd_data;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ptr;

  // Decoded outputs and their next values
  logic [4:0] bias_r, bias_nxt;
  logic       ctl_amp_r, ctl_amp_nxt;
  logic       ctv_amp_r, ctv_amp_nxt;
  logic       ninv_r, ninv_nxt;
  logic       temp_r, temp_nxt;
  logic       rte_r, rte_nxt;
  logic       pin_two_r, pin_two_nxt;

  // Bus slave
  afe_i2c_slave afe_i2c_slave_inst (
    .i_sys_clk         (i_sys_clk),
    .i_reset           (i_reset),
    .i_scl             (i_scl),
    .i_sda             (i_sda),
    .i_module_select_n (i_module_select_n),
    .o_sda_oe_n        (o_sda_oe_n),
    .o_wr_stb          (wr_stb),
    .o_wr_addr         (wr_addr),
    .o_wr_data         (wr_data),
    .o_ptr             (ptr),
    .i_rd_data         (rd_data)
  );

  // Bias code to percent of reference
  // Codes 0 to 2 pass straight through, a code n above them gives 2n-2
  // The top codes clamp, so no code reaches past the largest step
  function automatic logic [4:0] afe_bias_pct(input logic [3:0] code);
    logic [4:0] dbl;
    dbl = {code, 1'b0};
    if (code < AFE_BIAS_LIN) begin
      afe_bias_pct = {1'b0, code};
    end else if (dbl - 5'h02 > AFE_BIAS_MAX) begin
      afe_bias_pct = AFE_BIAS_MAX;
    end else begin
      afe_bias_pct = dbl - 5'h02;
    end
  endfunction : afe_bias_pct

  // Register writes
  always_comb begin
    status_nxt = status_r;
    lock_nxt   = lock_r;
    amp_nxt    = amp_r;
    ref_nxt    = ref_r;
    mode_nxt   = mode_r;
    status_nxt[0] = 1'b1; // Ready once out of reset
    // Unmapped offsets and the read-only status ignore writes
    if (wr_stb) begin
      case (wr_addr)
        AFE_OFS_LOCK: lock_nxt = wr_data & AFE_MSK_LOCK;
        AFE_OFS_AMP: begin
          if (!lock_r[AFE_LOCK_BIT]) begin
            amp_nxt = wr_data & AFE_MSK_AMP;
          end
        end
        AFE_OFS_REF: begin
          if (!lock_r[AFE_LOCK_BIT]) begin
            ref_nxt = wr_data & AFE_MSK_REF;
          end
        end
        AFE_OFS_MODE: mode_nxt = wr_data & AFE_MSK_MODE;
        default: ;
      endcase
    end
  end

  // Register read mux
  always_comb begin
    case (ptr)
      AFE_OFS_STATUS: rd_data = status_r;
      AFE_OFS_LOCK:   rd_data = lock_r;
      AFE_OFS_AMP:    rd_data = amp_r;
      AFE_OFS_REF:    rd_data = ref_r;
      AFE_OFS_MODE:   rd_data = mode_r;
      default:        rd_data = 8'h00;
    endcase
  end

  // Mode decode into amplifier power and routing
  always_comb begin
    bias_nxt    = afe_bias_pct(ref_r[AFE_BIAS_LSB +: 4]);
    ctl_amp_nxt = 1'b0;
    ctv_amp_nxt = 1'b0;
    ninv_nxt    = 1'b0;
    temp_nxt    = 1'b0;
    rte_nxt     = 1'b0;
    pin_two_nxt = 1'b0;
    case (mode_r[AFE_OPM_LSB +: 3])
      AFE_OPM_GALV: begin
        ctv_amp_nxt = 1'b1;
        ninv_nxt    = 1'b1;
      end
      AFE_OPM_STANDBY: ctl_amp_nxt = 1'b1;
      AFE_OPM_AMPERO: begin
        ctl_amp_nxt = 1'b1;
        ctv_amp_nxt = 1'b1;
      end
      AFE_OPM_TEMPOFF: begin
        ctl_amp_nxt = 1'b1;
        temp_nxt    = 1'b1;
        rte_nxt     = 1'b1;
      end
      AFE_OPM_TEMPON: begin
        ctl_amp_nxt = 1'b1;
        ctv_amp_nxt = 1'b1;
        temp_nxt    = 1'b1;
        rte_nxt     = 1'b1;
        pin_two_nxt = 1'b1;
      end
      default: ;
    endcase
  end

  // Register bank
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      status_r <= AFE_RST_STATUS;
      lock_r   <= AFE_RST_LOCK;
      amp_r    <= AFE_RST_AMP;
      ref_r    <= AFE_RST_REF;
      mode_r   <= AFE_RST_MODE;
    end else begin
      status_r <= status_nxt;
      lock_r   <= lock_nxt;
      amp_r    <= amp_nxt;
      ref_r    <= ref_nxt;
      mode_r   <= mode_nxt;
    end
  end

  // Decoded outputs, one cycle behind the mode and reference registers
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bias_r    <= 5'h00;
      ctl_amp_r <= 1'b0;
      ctv_amp_r <= 1'b0;
      ninv_r    <= 1'b0;
      temp_r    <= 1'b0;
      rte_r     <= 1'b0;
      pin_two_r <= 1'b0;
    end else begin
      bias_r    <= bias_nxt;
      ctl_amp_r <= ctl_amp_nxt;
      ctv_amp_r <= ctv_amp_nxt;
      ninv_r    <= ninv_nxt;
      temp_r    <= temp_nxt;
      rte_r     <= rte_nxt;
      pin_two_r <= pin_two_nxt;
    end
  end

  // Bus data value: open drain, so only a low is ever driven
  assign o_sda                 = 1'b0;
  // Amplifier and reference fields straight from the registers; bias percent from the decoded bias_r
  assign o_feedback_gain_sel   = amp_r[AFE_GAIN_LSB +: 3];
  assign o_ext_feedback        = (amp_r[AFE_GAIN_LSB +: 3] == AFE_GAIN_EXT);
  assign o_load_sel            = amp_r[AFE_RLOAD_LSB +: 2];
  assign o_ref_external        = ref_r[AFE_SRC_BIT];
  assign o_zero_sel            = ref_r[AFE_ZERO_LSB +: 2];
  assign o_zero_bypass         = (ref_r[AFE_ZERO_LSB +: 2] == AFE_ZERO_BYPASS);
  assign o_bias_positive       = ref_r[AFE_SIGN_BIT];
  assign o_bias_pct            = bias_r;
  // Mode fields and decoded amplifier controls
  assign o_electrode_short_switch    = mode_r[AFE_SHORT_BIT];
  assign o_control_amplifier_on      = ctl_amp_r;
  assign o_current_to_voltage_amp_on = ctv_amp_r;
  assign o_amp_noninverting          = ninv_r;
  assign o_temp_sensor_on            = temp_r;
  assign o_analog_output_pin_temp    = rte_r;
  assign o_feedback_pin_two_result   = pin_two_r;
  assign o_operating_mode_sel        = mode_r[AFE_OPM_LSB +: 3];
  // Status
  assign o_ready                     = status_r[0];
endmodule : afe_mode_config

/* File: verilog/afe_pkg.sv */
// Constants for the sensor front end configuration block
// Functional notes
// - Bias field codes map to 0,1,2,4 then +2% per code up to 24%.
// - Mode register at 0x12; bit 7 sets electrode short; bits 6..3 reserved.
// - Mode bits 2..0 pick sleep, galvanic, standby, amperometric, temperature.
// - Temperature mode, amplifier on: sensor to output, result to pin two.
// - Amperometric mode powers control and current-to-voltage amplifiers.
// - Galvanic: control amp off, other amp non-inverting; host sets bypass.
// - Bus traffic is accepted only while module select is low.
// - Only the selected device acknowledges; others leave data released.
// - Slave address is fixed; selection needs module select low and a matching address.
// - Fixed address is 1001000; select stays low for the whole transaction.
// - Amplifier and reference registers take writes only while lock bit is 0.
// - Gain code 000, the reset value, selects the external feedback resistor.
// - Zero select code 11 bypasses the internal zero circuitry.
package afe_pkg;
  // Bus address and register offsets
  localparam logic [6:0] AFE_SLAVE_ADDR = 7'h48;
  localparam logic [7:0] AFE_OFS_STATUS = 8'h00;
  localparam logic [7:0] AFE_OFS_LOCK   = 8'h01;
  localparam logic [7:0] AFE_OFS_AMP    = 8'h10;
  localparam logic [7:0] AFE_OFS_REF    = 8'h11;
  localparam logic [7:0] AFE_OFS_MODE   = 8'h12;
  // Reset values
  localparam logic [7:0] AFE_RST_STATUS = 8'h00;
  localparam logic [7:0] AFE_RST_LOCK   = 8'h01;
  localparam logic [7:0] AFE_RST_AMP    = 8'h03;
  localparam logic [7:0] AFE_RST_REF    = 8'h20;
  localparam logic [7:0] AFE_RST_MODE   = 8'h00;
  // Writable bits; reserved bits store nothing and read as zero
  localparam logic [7:0] AFE_MSK_LOCK   = 8'h01;
  localparam logic [7:0] AFE_MSK_AMP    = 8'h1F;
  localparam logic [7:0] AFE_MSK_REF    = 8'hFF;
  localparam logic [7:0] AFE_MSK_MODE   = 8'h87;
  // Field positions
  localparam int AFE_LOCK_BIT   = 0;
  localparam int AFE_GAIN_LSB   = 2;
  localparam int AFE_RLOAD_LSB  = 0;
  localparam int AFE_SRC_BIT    = 7;
  localparam int AFE_ZERO_LSB   = 5;
  localparam int AFE_SIGN_BIT   = 4;
  localparam int AFE_BIAS_LSB   = 0;
  localparam int AFE_SHORT_BIT  = 7;
  localparam int AFE_OPM_LSB    = 0;
  // Field codes
  localparam logic [2:0] AFE_OPM_SLEEP   = 3'h0;
  localparam logic [2:0] AFE_OPM_GALV    = 3'h1;
  localparam logic [2:0] AFE_OPM_STANDBY = 3'h2;
  localparam logic [2:0] AFE_OPM_AMPERO  = 3'h3;
  localparam logic [2:0] AFE_OPM_TEMPOFF = 3'h6;
  localparam logic [2:0] AFE_OPM_TEMPON  = 3'h7;
  localparam logic [2:0] AFE_GAIN_EXT    = 3'h0;
  localparam logic [1:0] AFE_ZERO_BYPASS = 2'h3;
  localparam logic [3:0] AFE_BIAS_LIN    = 4'h3;
  localparam logic [4:0] AFE_BIAS_MAX    = 5'h18;
endpackage : afe_pkg

/* File: verilog/afe_i2c_slave.sv */
// Bus slave with fixed address and module select gating
`timescale 1ns/1ns
module afe_i2c_slave (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  // Bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_module_select_n,
  output logic            o_sda_oe_n,
  // Register port
  output logic            o_wr_stb,
  output logic [7:0]      o_wr_addr,
  output logic [7:0]      o_wr_data,
  output logic [7:0]      o_ptr,
  input  wire logic [7:0] i_rd_data
);
  import afe_pkg::*;

  typedef enum logic [2:0] {
    AFE_ST_IDLE, AFE_ST_ADDR, AFE_ST_PTR, AFE_ST_WDATA, AFE_ST_READ
  } afe_st_t;

  afe_st_t     st_r, st_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [7:0]  ptr_r, ptr_nxt;
  logic        drv_r, drv_nxt;
  logic        stb_r, stb_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic        scl_r, sda_r;
  logic        rise, fall, start, stop, sel;

  // Edge and bus condition detection
  assign sel   = ~i_module_select_n;
  assign rise  = i_scl & ~scl_r;
  assign fall  = ~i_scl & scl_r;
  assign start = i_scl & scl_r & sda_r & ~i_sda;
  assign stop  = i_scl & scl_r & ~sda_r & i_sda;

  // Next state of the bit engine
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    ptr_nxt = ptr_r;
    drv_nxt = drv_r;
    stb_nxt = 1'b0;
    wd_nxt  = wd_r;
    if (!sel || stop) begin
      st_nxt  = AFE_ST_IDLE;
      drv_nxt = 1'b0;
    end else if (start) begin
      st_nxt  = AFE_ST_ADDR;
      cnt_nxt = 4'hF; // Wait for the clock fall that closes the start
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        AFE_ST_IDLE: begin
          drv_nxt = 1'b0;
        end
        AFE_ST_READ: begin
          if (rise && cnt_r == 4'h8 && i_sda) begin
            st_nxt = AFE_ST_IDLE; // Master NACK ends the read
          end else if (fall) begin
            if (cnt_r < 4'h7) begin
              cnt_nxt = cnt_r + 4'h1;
              sh_nxt  = {sh_r[6:0], 1'b0};
              drv_nxt = ~sh_r[6];
            end else if (cnt_r == 4'h7) begin
              cnt_nxt = 4'h8;
              drv_nxt = 1'b0;
            end else begin
              cnt_nxt = 4'h0;
              sh_nxt  = i_rd_data;
              drv_nxt = ~i_rd_data[7];
            end
          end
        end
        default: begin
          if (rise && cnt_r < 4'h8) begin
            sh_nxt = {sh_r[6:0], i_sda};
          end
          if (fall && cnt_r == 4'hF) begin
            cnt_nxt = 4'h0; // Clock low after a start carries no bit
          end else if (fall && cnt_r < 4'h7) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h7) begin
            cnt_nxt = 4'h8;
            case (st_r)
              AFE_ST_ADDR: drv_nxt = (sh_r[7:1] == AFE_SLAVE_ADDR);
              AFE_ST_PTR: begin
                drv_nxt = 1'b1;
                ptr_nxt = sh_r;
              end
              default: begin
                drv_nxt = 1'b1;
                stb_nxt = 1'b1;
                wd_nxt  = sh_r;
              end
            endcase
          end else if (fall) begin
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
            case (st_r)
              AFE_ST_ADDR: begin
                if (sh_r[7:1] != AFE_SLAVE_ADDR) begin
                  st_nxt = AFE_ST_IDLE;
                end else if (sh_r[0]) begin
                  st_nxt  = AFE_ST_READ;
                  sh_nxt  = i_rd_data;
                  drv_nxt = ~i_rd_data[7];
                end else begin
                  st_nxt = AFE_ST_PTR;
                end
              end
              default: st_nxt = AFE_ST_WDATA;
            endcase
          end
        end
      endcase
    end
  end

  // Registers of the bit engine
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_r  <= AFE_ST_IDLE;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      ptr_r <= 8'h00;
      drv_r <= 1'b0;
      stb_r <= 1'b0;
      wd_r  <= 8'h00;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      ptr_r <= ptr_nxt;
      drv_r <= drv_nxt;
      stb_r <= stb_nxt;
      wd_r  <= wd_nxt;
      scl_r <= i_scl;
      sda_r <= i_sda;
    end
  end

  assign o_sda_oe_n = ~drv_r;
  assign o_wr_stb   = stb_r;
  assign o_wr_addr  = ptr_r;
  assign o_wr_data  = wd_r;
  assign o_ptr      = ptr_r;
endmodule : afe_i2c_slave

/* File: tb/afe_mode_config_assertions.sv */
// Port checks of the sensor front end configuration block
`timescale 1ns/1ns
module afe_mode_config_chk
  import afe_pkg::*;
(
  // Clock, reset and select
  input wire logic       i_sys_clk,
  input wire logic       i_reset,
  input wire logic       i_module_select_n,
  // Watched outputs
  input wire logic       o_sda_oe_n,
  input wire logic [2:0] o_feedback_gain_sel,
  input wire logic       o_ext_feedback,
  input wire logic [1:0] o_zero_sel,
  input wire logic       o_zero_bypass,
  input wire logic [4:0] o_bias_pct,
  input wire logic       o_control_amplifier_on,
  input wire logic       o_current_to_voltage_amp_on,
  input wire logic       o_amp_noninverting,
  input wire logic       o_temp_sensor_on,
  input wire logic       o_analog_output_pin_temp,
  input wire logic       o_feedback_pin_two_result,
  input wire logic [2:0] o_operating_mode_sel
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Static field relations
  chk_ext_gain: assert property (
    o_ext_feedback == (o_feedback_gain_sel == AFE_GAIN_EXT))
    else $error("external feedback flag wrong");
  chk_zero_bypass: assert property (
    o_zero_bypass == (o_zero_sel == AFE_ZERO_BYPASS))
    else $error("zero bypass flag wrong");
  chk_bias_max: assert property (o_bias_pct <= AFE_BIAS_MAX)
    else $error("bias percent above top");
  // Mode decode, one cycle behind the register; select gating of data line and mode
  chk_ampero_on: assert property (
    o_operating_mode_sel == AFE_OPM_AMPERO |=>
    o_control_amplifier_on && o_current_to_voltage_amp_on)
    else $error("amperometric amplifiers off");
  chk_galv_mode: assert property (
    o_operating_mode_sel == AFE_OPM_GALV |=> !o_control_amplifier_on
    && o_current_to_voltage_amp_on && o_amp_noninverting)
    else $error("galvanic setup wrong");
  chk_temp_route: assert property (
    o_operating_mode_sel == AFE_OPM_TEMPON |=>
    o_analog_output_pin_temp && o_feedback_pin_two_result)
    else $error("temperature routing wrong");
  chk_sleep_off: assert property (
    o_operating_mode_sel inside {3'h0, 3'h4, 3'h5} |=>
    !(o_control_amplifier_on || o_current_to_voltage_amp_on
    || o_temp_sensor_on))
    else $error("sleep mode left power on");
  chk_unsel_quiet: assert property (
    i_module_select_n [*3] |-> o_sda_oe_n)
    else $error("data line driven while unselected");
  chk_mode_gated: assert property (
    $changed(o_operating_mode_sel) |-> !$past(i_module_select_n))
    else $error("mode changed while unselected");
endmodule : afe_mode_config_chk

bind afe_mode_config afe_mode_config_chk afe_mode_config_chk_inst (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset),
  .i_module_select_n(i_module_select_n), .o_sda_oe_n(o_sda_oe_n),
  .o_feedback_gain_sel(o_feedback_gain_sel),
  .o_ext_feedback(o_ext_feedback), .o_zero_sel(o_zero_sel),
  .o_zero_bypass(o_zero_bypass), .o_bias_pct(o_bias_pct),
  .o_control_amplifier_on(o_control_amplifier_on),
  .o_current_to_voltage_amp_on(o_current_to_voltage_amp_on),
  .o_amp_noninverting(o_amp_noninverting),
  .o_temp_sensor_on(o_temp_sensor_on),
  .o_analog_output_pin_temp(o_analog_output_pin_temp),
  .o_feedback_pin_two_result(o_feedback_pin_two_result),
  .o_operating_mode_sel(o_operating_mode_sel));

/* File: tb/afe_i2c_host.sv */
// Bus master model that selects the block and moves register bytes
`timescale 1ns/1ns
module afe_i2c_host (
  // Clock and wire level
  input  wire logic i_clk,
  input  wire logic i_sda,
  // Driven pins
  output logic      o_scl,
  output logic      o_sda_drv,
  output logic      o_sel_n
);
  // Idle bus, device not selected
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b1;
    o_sel_n = 1'b1;
  end
  // Wait clock edges; every pin change follows a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // One bit slot, four clocks per phase; wire level returned
  task automatic bt(input logic b, output logic r);
    o_sda_drv <= b;
    cyc(2);
    o_scl <= 1'b1;
    cyc(3);
    r = i_sda;
    cyc(1);
    o_scl <= 1'b0;
    cyc(2);
  endtask : bt
  // Start or repeated start
  task automatic st;
    o_sda_drv <= 1'b1;
    cyc(2);
    o_scl <= 1'b1;
    cyc(3);
    o_sda_drv <= 1'b0;
    cyc(3);
    o_scl <= 1'b0;
    cyc(2);
  endtask : st
  // Stop
  task automatic sp;
    o_sda_drv <= 1'b0;
    cyc(2);
    o_scl <= 1'b1;
    cyc(3);
    o_sda_drv <= 1'b1;
    cyc(3);
  endtask : sp
  // Byte out, MSB first, then the acknowledge slot
  task automatic wb(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ak = !r;
  endtask : wb
  // Byte in, closed by a master NACK
  task automatic rb(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, r);
      d[i] = r;
    end
    bt(1'b1, r);
  endtask : rb
  // One select held over a whole register write
  task automatic wr(input logic en, input logic [7:0] a, p, d,
                    output logic ak);
    logic x;
    o_sel_n <= !en;
    cyc(2);
    st();
    wb(a, ak);
    wb(p, x);
    wb(d, x);
    sp();
    o_sel_n <= 1'b1;
    cyc(2);
  endtask : wr
  // Pointer set, repeated start, one data byte
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic x;
    o_sel_n <= 1'b0;
    cyc(2);
    st();
    wb(8'h90, x);
    wb(p, x);
    st();
    wb(8'h91, x);
    rb(d);
    sp();
    o_sel_n <= 1'b1;
    cyc(2);
  endtask : rd
endmodule : afe_i2c_host

/* File: tb/afe_mode_config_test.sv */
// Self-checking bench of the sensor front end configuration block
`timescale 1ns/1ns
module afe_mode_config_test;
  import afe_pkg::*;
  logic clk, rst, scl, hdrv, seln, sdo, oe_n, ext, bp, bpos, rext, ak;
  logic sh, cam, cva, ni, tmp, vt, p2, rdy;
  logic [2:0] gain, opm;
  logic [1:0] ld, zs;
  logic [4:0] pct;
  logic [7:0] q[$], seen, d, rv, e;
  logic [31:0] r;
  logic [5:0] mt [8] = '{6'h00, 6'h18, 6'h20, 6'h30, 6'h00, 6'h00,
                         6'h26, 6'h37};
  int error_cnt = 0, tests_run = 0;
  string nm = "reset";
  event got;
  wire logic [7:0] mv = {1'b0, sh, cam, cva, ni, tmp, vt, p2};
  // Wired-AND bus data with pull-up
  wire logic sda = hdrv & (oe_n | sdo);
  afe_i2c_host afe_i2c_host_inst (.i_clk(clk), .i_sda(sda),
    .o_scl(scl), .o_sda_drv(hdrv), .o_sel_n(seln));
  afe_mode_config afe_mode_config_inst (.i_sys_clk(clk), .i_reset(rst),
    .i_scl(scl), .i_sda(sda), .i_module_select_n(seln), .o_sda(sdo),
    .o_sda_oe_n(oe_n), .o_feedback_gain_sel(gain), .o_ext_feedback(ext),
    .o_load_sel(ld), .o_ref_external(rext), .o_zero_sel(zs),
    .o_zero_bypass(bp), .o_bias_positive(bpos), .o_bias_pct(pct),
    .o_electrode_short_switch(sh), .o_control_amplifier_on(cam),
    .o_current_to_voltage_amp_on(cva), .o_amp_noninverting(ni),
    .o_temp_sensor_on(tmp), .o_analog_output_pin_temp(vt),
    .o_feedback_pin_two_result(p2), .o_operating_mode_sel(opm),
    .o_ready(rdy));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Note an expectation and hand the seen value to the monitor
  task ck(input logic [7:0] ex, v);
    q.push_back(ex);
    seen = v;
    ->got;
    #1;
  endtask : ck
  // Monitor takes the oldest note and compares
  always @(got) begin
    tests_run++;
    e = q.pop_front();
    if (e !== seen) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  end
  // Expected bias percent of a code
  function automatic logic [7:0] pexp(input logic [3:0] c);
    if (c < 4'h3) return {4'h0, c};
    if (c > 4'hD) return 8'h18;
    return {3'h0, c, 1'b0} - 8'h02;
  endfunction : pexp
  // Register write through the model, then let decode settle
  task w(input logic [7:0] p, v);
    afe_i2c_host_inst.wr(1'b1, 8'h90, p, v, ak);
    repeat (3) @(posedge clk);
  endtask : w
  task done(input string n);
    $display("Test %s finished", nm);
    nm = n;
  endtask : done
  task end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    #5_000_000;
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    r = $urandom(60443);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    ck(8'h00, mv);
    ck(AFE_RST_AMP, {3'h0, gain, ld});
    ck(8'h03, {6'h00, ext, rdy});
    ck(AFE_RST_REF, {rext, zs, bpos, 4'h0});
    ck(8'h00, {3'h0, pct});
    ck(8'h00, {7'h00, sdo});
    done("lock");
    w(AFE_OFS_AMP, 8'h1C);
    ck(AFE_RST_AMP, {3'h0, gain, ld});
    w(AFE_OFS_LOCK, 8'h00);
    w(AFE_OFS_AMP, 8'h1C);
    ck(8'h1C, {3'h0, gain, ld});
    ck(8'h00, {7'h00, ext});
    w(AFE_OFS_AMP, 8'h01);
    ck(8'h01, {7'h00, ext});
    done("bias");
    for (int c = 0; c < 16; c++) begin
      r = $urandom;
      d = {r[7:4], c[3:0]};
      w(AFE_OFS_REF, d);
      ck(pexp(d[3:0]), {3'h0, pct});
      ck({d[7:4], d[6:5] == 2'h3, 3'h0}, {rext, zs, bpos, bp, 3'h0});
    end
    done("modes");
    for (int i = 0; i < 8; i++) begin
      w(AFE_OFS_MODE, {i[0], 4'hF, i[2:0]});
      ck({1'b0, i[0], mt[i]}, mv);
      afe_i2c_host_inst.rd(AFE_OFS_MODE, rv);
      ck({i[0], 4'h0, i[2:0]}, rv);
    end
    done("select");
    afe_i2c_host_inst.wr(1'b0, 8'h90, AFE_OFS_MODE, 8'h03, ak);
    ck(8'h00, {7'h00, ak});
    afe_i2c_host_inst.wr(1'b1, 8'h92, AFE_OFS_MODE, 8'h03, ak);
    ck(8'h00, {7'h00, ak});
    afe_i2c_host_inst.wr(1'b1, 8'hA0, AFE_OFS_MODE, 8'h03, ak);
    ck(8'h00, {7'h00, ak});
    ck(8'h07, {5'h00, opm});
    afe_i2c_host_inst.rd(8'h05, rv);
    ck(8'h00, rv);
    done("end");
    end_of_test();
  end
endmodule : afe_mode_config_test
